// ---- design/aisc_pkg.sv ----
// aisc_pkg: constants and carrier types of the scan configuration bank
// assumes 16-bit serial frames, select code in the top five bits
package aisc_pkg;

	// frame layout
	localparam int unsigned frame_bits     = 16;
	localparam int unsigned select_msb     = 15;
	localparam int unsigned select_lsb     = 11;
	localparam int unsigned field_msb      = 10;
	localparam int unsigned field_lsb      = 3;
	localparam int unsigned common_ref_bit = 2;
	localparam int unsigned config_bit     = 15;
	localparam int unsigned channels       = 16;
	localparam int unsigned pairs          = 8;
	localparam int unsigned common_ch_max  = 14;

	// link bit counter
	localparam logic [4:0] last_bit_count  = 5'h0f;
	localparam logic [4:0] frame_end_count = 5'h10;

	// select codes
	localparam logic [4:0] pseudo_diff_select_code = 5'h11;
	localparam logic [4:0] bipolar_select_code     = 5'h12;
	localparam logic [4:0] upper_mask_select_code  = 5'h14;
	localparam logic [4:0] lower_mask_select_code  = 5'h15;
	localparam logic [4:0] sequence_select_code    = 5'h16;

	// reset values
	localparam logic [7:0]  pair_cfg_reset   = 8'h00;
	localparam logic        common_ref_reset = 1'b0;
	localparam logic [15:0] scan_mask_reset  = 16'h0000;
	localparam logic [7:0]  seq_len_reset    = 8'h00;
	localparam logic [15:0] mode_word_reset  = 16'h0000;

	// configuration as stored; pair index p covers channels 2p and 2p+1
	typedef struct packed {
		logic [7:0]  pseudo_diff;
		logic [7:0]  bipolar;
		logic        common_reference_enable;
		logic [15:0] scan_include;
		logic [7:0]  sequence_count_field;
	} aisc_cfg_type;

	// per-channel conversion setup seen by the converter
	typedef struct packed {
		logic [15:0] twos_complement;
		logic [15:0] pair_mode;
		logic [15:0] common_ref;
	} aisc_chan_type;

	// instruction handed to the sequencer
	typedef struct packed {
		logic        start;
		logic        pending;
		logic [15:0] word;
	} aisc_mode_type;

endpackage

// ---- design/aisc_sync2.sv ----
// aisc_sync2: two-flop level synchroniser into the system clock
// assumes inputs are levels or toggles held long enough to be seen
`timescale 1ns/1ps
module aisc_sync2 #(
	parameter int unsigned width = 1
) (
	input  wire logic             clk_sys_i,
	input  wire logic             reset_n_i,
	input  wire logic [width-1:0] async_i,
	input  wire logic [width-1:0] reset_val_i,
	output logic      [width-1:0] sync_o
);

	logic [width-1:0] meta;

	// first flop feeds only the second
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			meta   <= reset_val_i;
			sync_o <= reset_val_i;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule

// ---- design/aisc_scan_cfg.sv ----
// aisc_scan_cfg: serial-loaded scan configuration bank of a multichannel
// converter, with mode-instruction hand-off to the conversion sequencer.
// assumes sclk_i only runs inside frames, din_i launched on sclk falling,
// and conv_busy_i driven by the sequencer on clk_sys_i.
// Functional notes
// RL1: code 10001 writes pseudo-differential pair register
// RL2: bits 10..3 pick pseudo-diff per pair, reset zero
// RL3: bit 2 refers inputs 0-14 to common
// RL4: code 10010 writes bipolar pair register
// RL5: bits 10..3 pick bipolar per pair, reset zero
// RL6: code 10100 sets scan mask channels 15..8
// RL7: mask bit one includes channel, reset zero
// RL8: code 10101 sets scan mask channels 7..0
// RL9: code 10110 writes sequence length register
// RL10: length field bits 10..3, conversions = field+1
// RL11: msb one configures, msb zero is mode instruction
// RL12: mode instruction starts at next chip-select fall; code skips falls while conv_busy_i is high
// RL13: config during sequence invalidates output data until mode
// RL14: pseudo-diff beats bipolar, giving unipolar binary
// RL15: common reference forces unipolar binary against shared input
// RL16: only bipolar pairs deliver two's complement
// RL17: sixteen-bit frames, unknown codes and bits 1..0 ignored
`timescale 1ns/1ps
module aisc_scan_cfg (
	input  wire logic                   clk_sys_i,
	input  wire logic                   reset_n_i,
	input  wire logic                   sclk_i,
	input  wire logic                   cs_n_i,
	input  wire logic                   din_i,
	input  wire logic                   conv_busy_i,
	output aisc_pkg::aisc_cfg_type      cfg_o,
	output aisc_pkg::aisc_chan_type     chan_o,
	output logic [8:0]                  seq_conversions_o,
	output logic [15:0]                 mode_word_o,
	output logic                        mode_start_o,
	output logic                        mode_pending_o,
	output logic                        dout_valid_o
);

	// helpers

	function automatic logic [4:0] select_of(input logic [15:0] w);
		select_of = w[aisc_pkg::select_msb:aisc_pkg::select_lsb];
	endfunction

	function automatic logic [7:0] field_of(input logic [15:0] w);
		field_of = w[aisc_pkg::field_msb:aisc_pkg::field_lsb];
	endfunction

	// sequence length is the stored field plus one, 1 to 256
	function automatic logic [8:0] conversions_of(input logic [7:0] f);
		conversions_of = {1'b0, f} + 9'h001;
	endfunction

	// frame bit 10 is pair 0, so the field is bit-reversed into pair order
	function automatic logic [7:0] pairs_of(input logic [15:0] w);
		logic [7:0] f;
		logic [7:0] r;
		f = field_of(w);
		r = '0;
		for (int p = 0; p < aisc_pkg::pairs; p++) begin
			r[p] = f[7-p];
		end
		pairs_of = r;
	endfunction

	// per-channel coding and input arrangement
	function automatic aisc_pkg::aisc_chan_type decode_chan(
		input aisc_pkg::aisc_cfg_type c
	);
		aisc_pkg::aisc_chan_type r;
		logic                    com;
		logic                    pd;
		logic                    bp;
		r = '0;
		for (int ch = 0; ch < aisc_pkg::channels; ch++) begin
			com = c.common_reference_enable && (ch <= aisc_pkg::common_ch_max); // [RL3]
			pd  = c.pseudo_diff[ch/2];
			bp  = c.bipolar[ch/2];
			r.common_ref[ch]      = com;                          // [RL15]
			r.pair_mode[ch]       = !com && (pd || bp);           // [RL2] [RL5]
			r.twos_complement[ch] = !com && !pd && bp;            // [RL14] [RL16]
		end
		decode_chan = r;
	endfunction

	// link domain: bit collection on sclk_i

	typedef struct packed {
		logic [15:0] shift;
		logic [4:0]  count;
	} aisc_frame_type;

	typedef struct packed {
		logic [15:0] word;
		logic        toggle;
		logic        begun;
	} aisc_capture_type;

	aisc_frame_type   frame;
	aisc_frame_type   next_frame;
	aisc_capture_type capture;
	aisc_capture_type next_capture;

	always_comb begin
		next_frame   = frame;
		next_capture = capture;
		// first bit of a frame stands for its chip-select fall, which may be
		// shorter than a system clock period and lost as a synced level
		if (frame.count == '0) begin  // [RL12]
			next_capture.begun = !capture.begun;
		end
		if (frame.count != aisc_pkg::frame_end_count) begin
			next_frame.shift = {frame.shift[14:0], din_i};
			next_frame.count = frame.count + 5'h01;
		end
		// only the sixteenth bit completes a word; extra bits are dropped
		if (frame.count == aisc_pkg::last_bit_count) begin  // [RL17]
			next_capture.word   = {frame.shift[14:0], din_i};
			next_capture.toggle = !capture.toggle;
		end
	end

	// chip select high ends the frame; a short frame never captures
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			frame <= '0;
		end else begin
			frame <= next_frame;
		end
	end

	// captured word holds still until the next full frame
	always_ff @(posedge sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			capture <= '0;
		end else begin
			capture <= next_capture;
		end
	end

	// crossing into the system clock
	logic [1:0] link_async;
	logic [1:0] link_sync;
	logic       toggle_sync;
	logic       begun_sync;

	// both are toggles, so a reset to zero matches the cleared capture
	assign link_async = {capture.toggle, capture.begun};

	aisc_sync2 #(
		.width (2)
	) u_link_sync (
		.clk_sys_i   (clk_sys_i),
		.reset_n_i   (reset_n_i),
		.async_i     (link_async),
		.reset_val_i (2'h0),
		.sync_o      (link_sync)
	);

	assign toggle_sync = link_sync[1];
	assign begun_sync  = link_sync[0];

	// system domain: register bank and mode hand-off

	typedef struct packed {
		aisc_pkg::aisc_cfg_type  cfg;
		aisc_pkg::aisc_chan_type chan;
		aisc_pkg::aisc_mode_type mode;
		logic [8:0]              seq_conversions;
		logic                    toggle_seen;
		logic                    begun_seen;
		logic                    dout_valid;
	} aisc_state_type;

	aisc_state_type s;
	aisc_state_type next_s;

	localparam aisc_pkg::aisc_cfg_type cfg_reset = '{
		pseudo_diff:             aisc_pkg::pair_cfg_reset,
		bipolar:                 aisc_pkg::pair_cfg_reset,
		common_reference_enable: aisc_pkg::common_ref_reset,
		scan_include:            aisc_pkg::scan_mask_reset,
		sequence_count_field:    aisc_pkg::seq_len_reset
	};

	logic        cs_fall;
	logic        word_arrived;
	logic [15:0] rx_word;

	always_comb begin
		next_s              = s;
		next_s.mode.start   = 1'b0;
		next_s.begun_seen   = begun_sync;
		next_s.toggle_seen  = toggle_sync;
		cs_fall             = begun_sync != s.begun_seen;
		word_arrived        = toggle_sync != s.toggle_seen;
		rx_word             = capture.word;

		// a held instruction waits for the running conversion, then for a
		// fresh chip-select fall
		if (s.mode.pending && cs_fall && !conv_busy_i) begin   // [RL12]
			next_s.mode.start   = 1'b1;
			next_s.mode.pending = 1'b0;
			next_s.dout_valid   = 1'b1;                         // [RL13]
		end

		if (word_arrived) begin
			if (rx_word[aisc_pkg::config_bit]) begin            // [RL11]
				unique case (select_of(rx_word))
					aisc_pkg::pseudo_diff_select_code: begin    // [RL1]
						next_s.cfg.pseudo_diff = pairs_of(rx_word);                // [RL2]
						next_s.cfg.common_reference_enable =
							rx_word[aisc_pkg::common_ref_bit];                     // [RL3]
					end
					aisc_pkg::bipolar_select_code: begin        // [RL4]
						next_s.cfg.bipolar = pairs_of(rx_word);                    // [RL5]
					end
					aisc_pkg::upper_mask_select_code: begin     // [RL6]
						next_s.cfg.scan_include[15:8] = field_of(rx_word);         // [RL7]
					end
					aisc_pkg::lower_mask_select_code: begin     // [RL8]
						next_s.cfg.scan_include[7:0] = field_of(rx_word);          // [RL7]
					end
					aisc_pkg::sequence_select_code: begin       // [RL9]
						next_s.cfg.sequence_count_field = field_of(rx_word);       // [RL10]
					end
					default: begin
						// codes owned by other blocks or unused
					end
				endcase
				// sequencer keeps its scan; data after it is stale
				if (conv_busy_i) begin
					next_s.dout_valid = 1'b0;                   // [RL13]
				end
			end else begin
				next_s.mode.word    = rx_word;                  // [RL11]
				next_s.mode.pending = 1'b1;                     // [RL12]
			end
		end

		next_s.chan            = decode_chan(next_s.cfg);
		next_s.seq_conversions = conversions_of(next_s.cfg.sequence_count_field); // [RL10]
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			s.cfg             <= cfg_reset;                     // [RL2] [RL5] [RL7]
			s.chan            <= decode_chan(cfg_reset);
			s.mode.start      <= 1'b0;
			s.mode.pending    <= 1'b0;
			s.mode.word       <= aisc_pkg::mode_word_reset;
			s.seq_conversions <= conversions_of(aisc_pkg::seq_len_reset);
			s.toggle_seen     <= 1'b0;
			s.begun_seen      <= 1'b0;
			s.dout_valid      <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// outputs, all from flops

	assign cfg_o             = s.cfg;
	assign chan_o            = s.chan;
	assign seq_conversions_o = s.seq_conversions;
	assign mode_word_o       = s.mode.word;
	assign mode_start_o      = s.mode.start;
	assign mode_pending_o    = s.mode.pending;
	assign dout_valid_o      = s.dout_valid;

endmodule

// ---- testbench/aisc_scan_cfg_properties.sv ----
// aisc_scan_cfg_properties: port-level checks of the scan configuration bank
// assumes binding to aisc_scan_cfg, all checks in the clk_sys domain
`timescale 1ns/1ps
module aisc_cfg_checker (
	input wire logic                    clk_sys_i,
	input wire logic                    reset_n_i,
	input wire logic                    sclk_i,
	input wire logic                    cs_n_i,
	input wire logic                    din_i,
	input wire logic                    conv_busy_i,
	input wire aisc_pkg::aisc_cfg_type  cfg_o,
	input wire aisc_pkg::aisc_chan_type chan_o,
	input wire logic [8:0]              seq_conversions_o,
	input wire logic [15:0]             mode_word_o,
	input wire logic                    mode_start_o,
	input wire logic                    mode_pending_o,
	input wire logic                    dout_valid_o
);
	logic [15:0] exp_com;
	logic [15:0] exp_pair;
	logic [15:0] exp_twos;
	// per-channel coding expected from the stored bits
	always_comb begin
		for (int ch = 0; ch < 16; ch++) begin
			exp_com[ch] = cfg_o.common_reference_enable && (ch <= 14);
			exp_pair[ch] = !exp_com[ch] && (cfg_o.pseudo_diff[ch/2] || cfg_o.bipolar[ch/2]);
			exp_twos[ch] = !exp_com[ch] && !cfg_o.pseudo_diff[ch/2] && cfg_o.bipolar[ch/2];
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_link_quiet;
		cs_n_i [*8];
	endsequence
	sequence s_hand_off;
		mode_pending_o ##1 mode_start_o;
	endsequence
	a_len_plus_one: assert property (seq_conversions_o == {1'b0, cfg_o.sequence_count_field} + 9'h001)
		else $error("sequence count mismatch");
	a_pair_map: assert property (chan_o.pair_mode == exp_pair)
		else $error("pair mode mismatch");
	a_twos_map: assert property (chan_o.twos_complement == exp_twos)
		else $error("coding mismatch");
	a_common_map: assert property (chan_o.common_ref == exp_com)
		else $error("common reference mismatch");
	a_start_after_wait: assert property (s_hand_off |-> !mode_pending_o ##1 !mode_start_o)
		else $error("start pulse malformed");
	a_start_needs_pending: assert property (mode_start_o |-> $past(mode_pending_o))
		else $error("start without pending");
	a_pending_mode_word: assert property (mode_pending_o |-> !mode_word_o[15])
		else $error("pending word is a config");
	a_fall_needs_busy: assert property ($fell(dout_valid_o) |-> $past(conv_busy_i))
		else $error("output invalidated while idle");
	a_rise_needs_start: assert property ($rose(dout_valid_o) |-> mode_start_o)
		else $error("output valid without start");
	a_quiet_stable: assert property (s_link_quiet |=> $stable(cfg_o))
		else $error("config changed without frame");
endmodule
bind aisc_scan_cfg aisc_cfg_checker u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
	.sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .conv_busy_i(conv_busy_i), .cfg_o(cfg_o),
	.chan_o(chan_o), .seq_conversions_o(seq_conversions_o), .mode_word_o(mode_word_o),
	.mode_start_o(mode_start_o), .mode_pending_o(mode_pending_o), .dout_valid_o(dout_valid_o));

// ---- testbench/aisc_host_model.sv ----
// aisc_host_model: serial host that frames words into the bank
// assumes the bench calls send just after a clk_sys edge
`timescale 1ns/1ps
module aisc_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o
);
	initial begin
		sclk_o = 1'b0;
		din_o = 1'b0;
		// rise after time zero so the frame clear sees an edge
		#1 cs_n_o = 1'b1;
	end
	// msb first, data moves while clock low
	task automatic send(input logic [15:0] w, input int n);
		cs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			din_o = w[15-i];
			#3 sclk_o = 1'b1;
			#3 sclk_o = 1'b0;
		end
		#3 cs_n_o = 1'b1;
		// released line does not keep its level
		din_o = ~din_o;
		#300;
	endtask
endmodule

// ---- testbench/tb_top.sv ----
// tb_top: self-checking bench of the scan configuration bank
// assumes the host model and bound checker are compiled alongside
`timescale 1ns/1ps
module tb_top;
	logic                    clk_sys_i;
	logic                    reset_n_i;
	logic                    conv_busy_i;
	wire                     sclk;
	wire                     cs_n;
	wire                     din;
	aisc_pkg::aisc_cfg_type  cfg;
	aisc_pkg::aisc_cfg_type  exp_cfg;
	aisc_pkg::aisc_chan_type chan;
	logic [8:0]              seq_conv;
	logic [15:0]             mode_word;
	logic                    mode_start;
	logic                    mode_pending;
	logic                    dout_valid;
	int                      mismatches;
	int                      checks_done;
	int                      starts;
	int                      cycles;
	aisc_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
	aisc_scan_cfg dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .din_i(din), .conv_busy_i(conv_busy_i), .cfg_o(cfg), .chan_o(chan),
		.seq_conversions_o(seq_conv), .mode_word_o(mode_word), .mode_start_o(mode_start),
		.mode_pending_o(mode_pending), .dout_valid_o(dout_valid));
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (mode_start === 1'b1) begin
			starts <= starts + 1;
		end
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			test_done();
		end
	end
	task automatic test_done();
		if (mismatches == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [40:0] got, input logic [40:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic frame(input logic [4:0] code, input logic [7:0] fld, input logic [2:0] low,
		input int n);
		@(posedge clk_sys_i);
		#1;
		host.send({code, fld, low}, n);
		repeat (8) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic t_reset();
		chk(cfg, 41'h0);
		chk(seq_conv, 9'h001);
		chk(dout_valid, 1'b1);
	endtask
	task automatic t_pairs();
		frame(5'h11, 8'hc5, 3'h3, 16);
		exp_cfg.pseudo_diff = 8'ha3;
		chk(cfg, exp_cfg);
		frame(5'h12, 8'h3a, 3'h4, 16);
		exp_cfg.bipolar = 8'h5c;
		chk(cfg, exp_cfg);
		frame(5'h11, 8'h0f, 3'h0, 16);
		exp_cfg.pseudo_diff = 8'hf0;
		chk(cfg, exp_cfg);
		chk(chan.twos_complement, 16'h00f0);
		chk(chan.pair_mode, 16'hfff0);
		frame(5'h11, 8'h0f, 3'h4, 16);
		exp_cfg.common_reference_enable = 1'b1;
		chk(cfg, exp_cfg);
		chk(chan.common_ref, 16'h7fff);
		chk(chan.twos_complement, 16'h0000);
	endtask
	task automatic t_masks();
		frame(5'h14, 8'h81, 3'h7, 16);
		frame(5'h15, 8'h7e, 3'h0, 16);
		exp_cfg.scan_include = 16'h817e;
		chk(cfg, exp_cfg);
		frame(5'h16, 8'hff, 3'h0, 16);
		exp_cfg.sequence_count_field = 8'hff;
		chk(seq_conv, 9'h100);
	endtask
	task automatic t_ignored();
		frame(5'h13, 8'hff, 3'h7, 16);
		frame(5'h1f, 8'hff, 3'h7, 16);
		frame(5'h14, 8'h00, 3'h0, 8);
		chk(cfg, exp_cfg);
	endtask
	task automatic t_mode();
		int s0;
		s0 = starts;
		frame(5'h02, 8'h46, 3'h5, 16);
		chk(mode_word, 16'h1235);
		chk(mode_pending, 1'b1);
		chk(cfg, exp_cfg);
		frame(5'h1f, 8'h00, 3'h0, 16);
		chk(starts - s0, 1);
		chk(mode_pending, 1'b0);
	endtask
	task automatic t_busy();
		conv_busy_i <= 1'b1;
		frame(5'h16, 8'h00, 3'h0, 16);
		exp_cfg.sequence_count_field = 8'h00;
		chk(seq_conv, 9'h001);
		chk(dout_valid, 1'b0);
		frame(5'h01, 8'h10, 3'h0, 16);
		frame(5'h1f, 8'h00, 3'h0, 16);
		chk(mode_pending, 1'b1);
		chk(mode_word, 16'h0880);
		chk(dout_valid, 1'b0);
		conv_busy_i <= 1'b0;
		frame(5'h1f, 8'h00, 3'h0, 16);
		chk(mode_pending, 1'b0);
		chk(dout_valid, 1'b1);
	endtask
	initial begin
		conv_busy_i = 1'b0;
		mismatches = 0;
		checks_done = 0;
		starts = 0;
		cycles = 0;
		exp_cfg = '0;
		// fall after time zero so the link capture sees its reset edge
		#1 reset_n_i = 1'b0;
		repeat (5) @(posedge clk_sys_i);
		#1 reset_n_i = 1'b1;
		t_reset();
		t_pairs();
		t_masks();
		t_ignored();
		t_mode();
		t_busy();
		test_done();
	end
endmodule
